// >>> csfl_pkg.sv
`default_nettype none
package csfl_pkg;

  // ----------------------------------------------------------------
  // Register map and bus
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_STATUS_A = 8'h00;
  localparam logic [7:0]  ADR_STATUS_B = 8'h04;
  localparam logic [7:0]  ADR_IRQ_STS  = 8'h08;
  localparam logic [7:0]  ADR_IRQ_MSK  = 8'h0c;
  localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int PTR_HI = 15;
  localparam int PTR_LO = 13;
  localparam int A_WRAP = 12;
  localparam int A_CLMP = 11;
  localparam int A_MASK = 9;
  localparam int DP_HI  = 8;
  localparam int B_MAP  = 12;
  localparam int B_TEST = 11;
  localparam int B_SXT  = 10;
  localparam int B_CRY  = 9;
  localparam int B_XF   = 4;
  localparam int PM_HI  = 1;
  localparam logic [15:0] RSV_ONES_A = 16'h0400;
  localparam logic [15:0] RSV_ONES_B = 16'h01ec;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0]  PTR_RST = 3'h0;
  localparam logic [8:0]  DP_RST  = 9'h000;
  localparam logic [1:0]  PM_NONE = 2'h0;
  localparam logic [1:0]  PM_L1   = 2'h1;
  localparam logic [1:0]  PM_L4   = 2'h2;
  localparam logic [1:0]  PM_R6   = 2'h3;
  localparam logic [1:0]  CMP_EQ  = 2'h0;
  localparam logic [1:0]  CMP_LT  = 2'h1;
  localparam logic [1:0]  CMP_GT  = 2'h2;
  localparam int          IRQ_W   = 3;
  localparam int          EV_WRAP = 0;
  localparam int          EV_TRAP = 1;
  localparam int          EV_TEST = 2;

  typedef enum logic [4:0] {
    OPC_NONE, OPC_LST0, OPC_LST1, OPC_SET_CONTROL_BIT_OP, OPC_CLEAR_CONTROL_BIT_OP, OPC_LOAD_AUX_POINTER_OP, OPC_MAR, OPC_IND,
    OPC_LDP, OPC_SPM, OPC_ADD, OPC_SUB, OPC_ADD16, OPC_SUB16, OPC_SHIFT,
    OPC_BCOV, OPC_TEST, OPC_AUX_COMPARE_OP, OPC_MSB_ALIGN_OP, OPC_TRAP
  } csfl_opc_t;

  typedef enum logic [2:0] {
    CB_CRY, CB_MAP, CB_MASK, CB_CLMP, CB_SXT, CB_TEST, CB_XF
  } csfl_cbit_t;

  typedef struct packed {
    logic        valid;
    csfl_opc_t   code;
    csfl_cbit_t  cbit;
    logic        flag;
    logic        ovf;
    logic [15:0] operand;
    logic [15:0] ar_val;
    logic [15:0] ar0_val;
  } csfl_op_t;

  typedef struct packed {
    logic [31:0] product;
    logic [15:0] data;
    logic [4:0]  shift;
    logic        no_ext;
    logic [6:0]  instr_lo;
  } csfl_dp_t;

endpackage : csfl_pkg
`default_nettype wire

// >>> csfl_status.sv
// Operation
// - Pointer write copies old pointer into backup
// - Load-status one copies backup into pointer
// - Pointer selects auxiliary register, several writers
// - Add carry sets, subtract borrow clears
// - Shifted add only sets, sub only clears
// - Carry resets to one; other updaters
// - Direct address is page plus low seven
// - Mask blocks maskable interrupts, not NMI
// - Mask set on reset and trap taken
// - Wrap flag sticky until branch, load, reset
// - Clamp mode saturates accumulator on overflow
// - Product shift: none, left1, left4, right6
// - Shift only on transfer, product untouched
// - Sign extend select controls scaling extension
// - External flag pin, set/clear, reset one
// - Reserved status bits read as ones
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module csfl_status
  import csfl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Core side
  input  wire csfl_op_t    op_i,
  input  wire csfl_dp_t    dp_i,
  input  wire logic        irq_req_i,
  input  wire logic        nmi_req_i,
  // Status and datapath results
  output logic      [15:0] status_word_a_o,
  output logic      [15:0] status_word_b_o,
  output logic             ext_flag_o,
  output logic             dual_ram_map_o,
  output logic      [15:0] direct_addr_o,
  output logic      [31:0] scaled_product_o,
  output logic      [31:0] scaled_data_o,
  output logic             clamp_mode_o,
  output logic             irq_accept_o,
  output logic             nmi_accept_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  logic [2:0]       aux_reg_pointer_r;
  logic [2:0]       aux_pointer_backup_r;
  logic             sticky_arith_wrap_flag_r;
  logic             clamp_mode_r;
  logic             global_irq_mask_r;
  logic [8:0]       page_base_pointer_r;
  logic             dual_ram_map_select_r;
  logic             test_result_flag_r;
  logic             sign_extend_select_r;
  logic             carry_r;
  logic             ext_flag_output_r;
  logic [1:0]       product_shift_select_r;
  logic [IRQ_W-1:0] irq_sts_r;
  logic [IRQ_W-1:0] irq_msk_r;
  logic [15:0]      word_a;
  logic [15:0]      word_b;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A bus write waits for a cycle with no core operation, so the two
  // writers never collide on one field.
  logic       bus_req;
  logic       bus_go;
  logic       bus_wr;
  logic       wr_a;
  logic       wr_b;
  logic       wr_sts;
  logic       wr_msk;
  logic       op_v;
  logic       ld_a;
  logic       ld_b;
  logic [15:0] ld_val;
  logic       set_control_bit_op;
  logic       clear_control_bit_op;
  logic       ptr_wr;
  logic       test_op;
  logic       test_set;
  logic       cmp_hit;
  logic [IRQ_W-1:0] ev;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_go  = bus_req & (~wb_we_i | ~op_i.valid);
  assign bus_wr  = bus_go & wb_we_i & (&wb_sel_i[1:0]);
  assign wr_a    = bus_wr & (wb_adr_i == ADR_STATUS_A);
  assign wr_b    = bus_wr & (wb_adr_i == ADR_STATUS_B);
  assign wr_sts  = bus_wr & (wb_adr_i == ADR_IRQ_STS);
  assign wr_msk  = bus_wr & (wb_adr_i == ADR_IRQ_MSK);

  assign op_v    = op_i.valid;
  assign ld_a    = wr_a | (op_v & (op_i.code == OPC_LST0));
  assign ld_b    = wr_b | (op_v & (op_i.code == OPC_LST1));
  assign ld_val  = op_v ? op_i.operand : wb_dat_i[15:0];
  assign set_control_bit_op    = op_v & (op_i.code == OPC_SET_CONTROL_BIT_OP);
  assign clear_control_bit_op    = op_v & (op_i.code == OPC_CLEAR_CONTROL_BIT_OP);
  assign ptr_wr  = op_v & ((op_i.code == OPC_LOAD_AUX_POINTER_OP) | (op_i.code == OPC_MAR) | (op_i.code == OPC_IND));

  always_comb begin
    case (op_i.operand[1:0])
      CMP_EQ:  cmp_hit = (op_i.ar_val == op_i.ar0_val);
      CMP_LT:  cmp_hit = (op_i.ar_val <  op_i.ar0_val);
      CMP_GT:  cmp_hit = (op_i.ar_val >  op_i.ar0_val);
      default: cmp_hit = (op_i.ar_val != op_i.ar0_val);
    endcase
  end

  assign test_op  = op_v & ((op_i.code == OPC_TEST) | (op_i.code == OPC_AUX_COMPARE_OP) | (op_i.code == OPC_MSB_ALIGN_OP));
  assign test_set = (op_i.code == OPC_TEST) ? op_i.flag :
                    (op_i.code == OPC_AUX_COMPARE_OP) ? cmp_hit :
                    (op_i.operand[1] ^ op_i.operand[0]);

  // ----------------------------------------------------------------
  // Auxiliary pointer and backup
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_reg_pointer_r    <= PTR_RST;
      aux_pointer_backup_r <= PTR_RST;
    end else if (ptr_wr) begin
      aux_reg_pointer_r    <= op_i.operand[2:0];
      aux_pointer_backup_r <= aux_reg_pointer_r;
    end else if (ld_b) begin
      aux_pointer_backup_r <= ld_val[PTR_HI:PTR_LO];
      aux_reg_pointer_r    <= ld_val[PTR_HI:PTR_LO];
    end else if (ld_a) begin
      aux_reg_pointer_r    <= ld_val[PTR_HI:PTR_LO];
    end
  end

  // ----------------------------------------------------------------
  // Carry
  // ----------------------------------------------------------------
  // The flag field carries the adder carry-out; for a subtraction a
  // carry-out of zero is a borrow.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_r <= 1'b1;
    end else if (op_v) begin
      case (op_i.code)
        OPC_ADD, OPC_SUB, OPC_SHIFT: carry_r <= op_i.flag;
        OPC_ADD16: if (op_i.flag) carry_r <= 1'b1;
        OPC_SUB16: if (!op_i.flag) carry_r <= 1'b0;
        OPC_SET_CONTROL_BIT_OP:  if (op_i.cbit == CB_CRY) carry_r <= 1'b1;
        OPC_CLEAR_CONTROL_BIT_OP:  if (op_i.cbit == CB_CRY) carry_r <= 1'b0;
        OPC_LST1:  carry_r <= op_i.operand[B_CRY];
        default:   carry_r <= carry_r;
      endcase
    end else if (wr_b) begin
      carry_r <= wb_dat_i[B_CRY];
    end
  end

  // ----------------------------------------------------------------
  // Mode and control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dual_ram_map_select_r <= 1'b0;
      clamp_mode_r          <= 1'b0;
      sign_extend_select_r  <= 1'b1;
      ext_flag_output_r     <= 1'b1;
    end else if (set_control_bit_op | clear_control_bit_op) begin
      if (op_i.cbit == CB_MAP)  dual_ram_map_select_r <= set_control_bit_op;
      if (op_i.cbit == CB_CLMP) clamp_mode_r          <= set_control_bit_op;
      if (op_i.cbit == CB_SXT)  sign_extend_select_r  <= set_control_bit_op;
      if (op_i.cbit == CB_XF)   ext_flag_output_r     <= set_control_bit_op;
    end else begin
      if (ld_a) clamp_mode_r <= ld_val[A_CLMP];
      if (ld_b) dual_ram_map_select_r <= ld_val[B_MAP];
      if (ld_b) sign_extend_select_r  <= ld_val[B_SXT];
    end
  end

  // Loading a status word never touches the mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_mask_r <= 1'b1;
    end else if (op_v & (op_i.code == OPC_TRAP)) begin
      global_irq_mask_r <= 1'b1;
    end else if ((set_control_bit_op | clear_control_bit_op) & (op_i.cbit == CB_MASK)) begin
      global_irq_mask_r <= set_control_bit_op;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_base_pointer_r <= DP_RST;
    end else if (ld_a) begin
      page_base_pointer_r <= ld_val[DP_HI:0];
    end else if (op_v & (op_i.code == OPC_LDP)) begin
      page_base_pointer_r <= op_i.operand[DP_HI:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      product_shift_select_r <= PM_NONE;
    end else if (op_v & (op_i.code == OPC_SPM)) begin
      product_shift_select_r <= op_i.operand[PM_HI:0];
    end else if (ld_b) begin
      product_shift_select_r <= ld_val[PM_HI:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky wrap flag and test flag
  // ----------------------------------------------------------------
  // A new overflow wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_arith_wrap_flag_r <= 1'b0;
    end else if (op_v & op_i.ovf) begin
      sticky_arith_wrap_flag_r <= 1'b1;
    end else if ((op_v & (op_i.code == OPC_BCOV)) | ld_a) begin
      sticky_arith_wrap_flag_r <= ld_a ? ld_val[A_WRAP] : 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_result_flag_r <= 1'b0;
    end else if (test_op) begin
      test_result_flag_r <= test_set;
    end else if ((set_control_bit_op | clear_control_bit_op) & (op_i.cbit == CB_TEST)) begin
      test_result_flag_r <= set_control_bit_op;
    end else if (ld_b) begin
      test_result_flag_r <= ld_val[B_TEST];
    end
  end

  // ----------------------------------------------------------------
  // Datapath side effects
  // ----------------------------------------------------------------
  // Shifting only the copy keeps the product register intact, so an
  // interrupt context save sees the raw value, not the shifted one.
  logic [31:0] ext_data;
  logic [31:0] shifted_data;
  assign ext_data     = {{16{sign_extend_select_r & ~dp_i.no_ext & dp_i.data[15]}}, dp_i.data};
  assign shifted_data = ext_data << dp_i.shift;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scaled_product_o <= 32'h0000_0000;
      scaled_data_o    <= 32'h0000_0000;
      direct_addr_o    <= 16'h0000;
    end else begin
      case (product_shift_select_r)
        PM_L1:   scaled_product_o <= {dp_i.product[30:0], 1'b0};
        PM_L4:   scaled_product_o <= {dp_i.product[27:0], 4'h0};
        PM_R6:   scaled_product_o <= {{6{dp_i.product[31]}}, dp_i.product[31:6]};
        default: scaled_product_o <= dp_i.product;
      endcase
      scaled_data_o <= shifted_data;
      direct_addr_o <= {page_base_pointer_r, dp_i.instr_lo};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt gating and event status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_accept_o <= 1'b0;
      nmi_accept_o <= 1'b0;
    end else begin
      irq_accept_o <= irq_req_i & ~global_irq_mask_r;
      nmi_accept_o <= nmi_req_i;
    end
  end

  assign ev[EV_WRAP] = op_v & op_i.ovf;
  assign ev[EV_TRAP] = op_v & (op_i.code == OPC_TRAP);
  assign ev[EV_TEST] = test_op & test_set;

  // Set wins over a write-one clear in the same cycle
  for (genvar g = 0; g < IRQ_W; g++) begin : g_sts
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        irq_sts_r[g] <= 1'b0;
      end else if (ev[g]) begin
        irq_sts_r[g] <= 1'b1;
      end else if (wr_sts & wb_dat_i[g]) begin
        irq_sts_r[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_msk_r <= '0;
      irq_o     <= 1'b0;
    end else begin
      if (wr_msk) irq_msk_r <= wb_dat_i[IRQ_W-1:0];
      irq_o <= |(irq_sts_r & irq_msk_r);
    end
  end

  // ----------------------------------------------------------------
  // Status words and bus read
  // ----------------------------------------------------------------
  assign word_a = RSV_ONES_A | {aux_reg_pointer_r, sticky_arith_wrap_flag_r, clamp_mode_r, 1'b0,
                                global_irq_mask_r, page_base_pointer_r};
  assign word_b = RSV_ONES_B | {aux_pointer_backup_r, dual_ram_map_select_r, test_result_flag_r,
                                sign_extend_select_r, carry_r, 4'h0, ext_flag_output_r, 2'h0,
                                product_shift_select_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= RD_UNMAPPED;
      status_word_a_o <= RSV_ONES_A;
      status_word_b_o <= RSV_ONES_B;
      ext_flag_o      <= 1'b1;
      dual_ram_map_o  <= 1'b0;
      clamp_mode_o    <= 1'b0;
    end else begin
      wb_ack_o        <= bus_go;
      status_word_a_o <= word_a;
      status_word_b_o <= word_b;
      ext_flag_o      <= ext_flag_output_r;
      dual_ram_map_o  <= dual_ram_map_select_r;
      clamp_mode_o    <= clamp_mode_r;
      case (wb_adr_i)
        ADR_STATUS_A: wb_dat_o <= {16'h0000, word_a};
        ADR_STATUS_B: wb_dat_o <= {16'h0000, word_b};
        ADR_IRQ_STS:  wb_dat_o <= {29'h0, irq_sts_r};
        ADR_IRQ_MSK:  wb_dat_o <= {29'h0, irq_msk_r};
        default:      wb_dat_o <= RD_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_backup_copy_ptr: assert property (@(posedge clk_i) disable iff (rst_i)
    ptr_wr |=> aux_pointer_backup_r == $past(aux_reg_pointer_r))
    else $error("backup did not take old pointer");
  a_lst_ptr_same: assert property (@(posedge clk_i) disable iff (rst_i)
    (ld_b & ~ptr_wr) |=> aux_reg_pointer_r == aux_pointer_backup_r)
    else $error("pointer and backup differ after load");
  a_add16_no_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_v & op_i.code == OPC_ADD16 & carry_r) |=> carry_r)
    else $error("shifted add cleared carry");
  a_sub_borrow_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_v & op_i.code == OPC_SUB & ~op_i.flag) |=> ~carry_r)
    else $error("borrow left carry set");
  a_mask_blocks_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (global_irq_mask_r & irq_req_i) |=> ~irq_accept_o)
    else $error("masked interrupt accepted");
  a_mask_lst_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ld_a | ld_b) & ~set_control_bit_op & ~clear_control_bit_op & ~ev[EV_TRAP] |=> $stable(global_irq_mask_r))
    else $error("status load changed mask");
  a_wrap_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (sticky_arith_wrap_flag_r & ~ld_a & ~(op_v & op_i.code == OPC_BCOV)) |=> sticky_arith_wrap_flag_r)
    else $error("wrap flag dropped");
  a_daddr_concat: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 direct_addr_o == {$past(page_base_pointer_r), $past(dp_i.instr_lo)})
    else $error("direct address wrong");
  a_rsv_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    ((status_word_a_o & RSV_ONES_A) == RSV_ONES_A) && ((status_word_b_o & RSV_ONES_B) == RSV_ONES_B))
    else $error("reserved bit reads zero");
  a_pm_right6: assert property (@(posedge clk_i) disable iff (rst_i)
    (product_shift_select_r == PM_R6) |=> scaled_product_o == {{6{$past(dp_i.product[31])}}, $past(dp_i.product[31:6])})
    else $error("right six shift wrong");

endmodule : csfl_status
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import csfl_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and bench model
  // ----------------------------------------------------------------
  `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, scaled_product_o, scaled_data_o, seed, rd;
  csfl_op_t    op_i;
  csfl_dp_t    dp_i;
  logic        irq_req_i, nmi_req_i, ext_flag_o, dual_ram_map_o, clamp_mode_o, irq_accept_o, nmi_accept_o, irq_o;
  logic [15:0] status_word_a_o, status_word_b_o, direct_addr_o;
  logic [2:0]  ptr, bak, sts_m, msk_m;
  logic        wrap, clmp, mask, map, test, sxt, cry, xf;
  logic [8:0]  dp;
  logic [1:0]  pm;
  int          n_mismatch = 0;
  int          total_checks = 0;

  always #4 clk_i = ~clk_i;

  csfl_status csfl_status_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .op_i(op_i), .dp_i(dp_i), .irq_req_i(irq_req_i), .nmi_req_i(nmi_req_i),
    .status_word_a_o(status_word_a_o), .status_word_b_o(status_word_b_o), .ext_flag_o(ext_flag_o),
    .dual_ram_map_o(dual_ram_map_o), .direct_addr_o(direct_addr_o), .scaled_product_o(scaled_product_o),
    .scaled_data_o(scaled_data_o), .clamp_mode_o(clamp_mode_o), .irq_accept_o(irq_accept_o),
    .nmi_accept_o(nmi_accept_o), .irq_o(irq_o));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0020_0003 : 32'h0);
    return seed;
  endfunction : rnd

  function automatic logic [15:0] word_a();
    return {ptr, wrap, clmp, 1'b1, mask, dp};
  endfunction : word_a

  function automatic logic [15:0] word_b();
    return {bak, map, test, sxt, cry, 4'hf, xf, 2'h3, pm};
  endfunction : word_b

  function automatic logic [31:0] exp_prod(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return 32'($signed(p) >>> 6);
      default: return p;
    endcase
  endfunction : exp_prod

  function automatic logic cmp(input csfl_op_t o);
    case (o.operand[1:0])
      2'h0: return o.ar_val == o.ar0_val;
      2'h1: return o.ar_val < o.ar0_val;
      2'h2: return o.ar_val > o.ar0_val;
      default: return o.ar_val != o.ar0_val;
    endcase
  endfunction : cmp

  // ----------------------------------------------------------------
  // Expected field updates, one operation at a time
  // ----------------------------------------------------------------
  task automatic model(input csfl_op_t o);
    logic v;
    v = (o.code == OPC_SET_CONTROL_BIT_OP);
    case (o.code)
      OPC_LST0: {ptr, wrap, clmp, dp} = {o.operand[15:11], o.operand[8:0]};
      OPC_LST1: {bak, ptr, map, test, sxt, cry, pm} = {o.operand[15:13], o.operand[15:9], o.operand[1:0]};
      OPC_SET_CONTROL_BIT_OP, OPC_CLEAR_CONTROL_BIT_OP: case (o.cbit)
        CB_CRY: cry = v;
        CB_MAP: map = v;
        CB_MASK: mask = v;
        CB_CLMP: clmp = v;
        CB_SXT: sxt = v;
        CB_TEST: test = v;
        default: xf = v;
      endcase
      OPC_LOAD_AUX_POINTER_OP, OPC_MAR, OPC_IND: {bak, ptr} = {ptr, o.operand[2:0]};
      OPC_LDP: dp = o.operand[8:0];
      OPC_SPM: pm = o.operand[1:0];
      OPC_ADD, OPC_SUB, OPC_SHIFT: cry = o.flag;
      OPC_ADD16: cry = cry | o.flag;
      OPC_SUB16: cry = cry & o.flag;
      OPC_BCOV: wrap = 1'b0;
      OPC_TEST: test = o.flag;
      OPC_AUX_COMPARE_OP: test = cmp(o);
      OPC_MSB_ALIGN_OP: test = o.operand[1] ^ o.operand[0];
      OPC_TRAP: {mask, sts_m[EV_TRAP]} = 2'h3;
      default: ;
    endcase
    if ((o.code == OPC_TEST || o.code == OPC_AUX_COMPARE_OP || o.code == OPC_MSB_ALIGN_OP) && test) sts_m[EV_TEST] = 1'b1;
    if (o.ovf) {wrap, sts_m[EV_WRAP]} = 2'h3;
  endtask : model

  // ----------------------------------------------------------------
  // Bus and operation drivers
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    csfl_op_t o;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (n >= 50) n_mismatch++;
    o = '0;
    o.valid = 1'b1;
    o.code = (a == ADR_STATUS_A) ? OPC_LST0 : OPC_LST1;
    o.operand = d[15:0];
    if (we && s[1:0] == 2'h3 && (a == ADR_STATUS_A || a == ADR_STATUS_B)) model(o);
    if (we && s[1:0] == 2'h3 && a == ADR_IRQ_STS) sts_m = sts_m & ~d[2:0];
    if (we && s[1:0] == 2'h3 && a == ADR_IRQ_MSK) msk_m = d[2:0];
    @(posedge clk_i);
  endtask : wb

  task automatic rd_words();
    wb(1'b0, ADR_STATUS_A, 4'hf, 32'h0);
    `CHK(rd, {16'h0, word_a()})
    wb(1'b0, ADR_STATUS_B, 4'hf, 32'h0);
    `CHK(rd, {16'h0, word_b()})
    wb(1'b0, ADR_IRQ_STS, 4'hf, 32'h0);
    `CHK(rd, {29'h0, sts_m})
    wb(1'b0, ADR_IRQ_MSK, 4'hf, 32'h0);
    `CHK(rd, {29'h0, msk_m})
  endtask : rd_words

  // Ops go back to back; the idle that ends a burst comes from check_all
  task automatic run(input csfl_op_t o);
    op_i <= o;
    model(o);
    @(posedge clk_i);
  endtask : run

  task automatic check_all();
    op_i <= '0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(status_word_a_o, word_a())
    `CHK(status_word_b_o, word_b())
    `CHK({ext_flag_o, dual_ram_map_o, clamp_mode_o}, {xf, map, clmp})
    `CHK(direct_addr_o, {dp, dp_i.instr_lo})
    `CHK(scaled_product_o, exp_prod(dp_i.product, pm))
    `CHK(scaled_data_o, {{16{sxt & ~dp_i.no_ext & dp_i.data[15]}}, dp_i.data} << dp_i.shift)
    `CHK({irq_accept_o, nmi_accept_o}, {irq_req_i & ~mask, nmi_req_i})
    `CHK(irq_o, |(sts_m & msk_m))
    @(posedge clk_i);
  endtask : check_all

  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end

  initial begin
    csfl_op_t o;
    logic [31:0] r;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {op_i, dp_i, irq_req_i, nmi_req_i} = '0;
    seed = 32'haa7cec47;
    {ptr, bak, wrap, clmp, mask, dp, map, test, sxt, cry, xf, pm, sts_m, msk_m} = {9'h001, 11'h000, 3'h7, 8'h00};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    check_all();
    rd_words();
    wb(1'b0, 8'h40, 4'hf, 32'h0);
    `CHK(rd, RD_UNMAPPED)
    wb(1'b1, ADR_STATUS_A, 4'hc, 32'h0000_ffff);
    wb(1'b1, ADR_STATUS_A, 4'hf, 32'h0000_e5ab);
    wb(1'b1, ADR_STATUS_B, 4'hf, 32'h0000_b2ff);
    rd_words();
    for (int c = 0; c < 14; c++) begin
      o = '0;
      o.valid = 1'b1;
      o.code = c[0] ? OPC_SET_CONTROL_BIT_OP : OPC_CLEAR_CONTROL_BIT_OP;
      o.cbit = csfl_cbit_t'(c[3:1]);
      run(o);
      check_all();
    end
    wb(1'b1, ADR_IRQ_STS, 4'hf, 32'h7);
    wb(1'b1, ADR_IRQ_MSK, 4'hf, 32'h3);
    // Trap and overflow each raise the line; masking then hides it
    for (int c = 0; c < 4; c++) begin
      o = '0;
      o.valid = 1'b1;
      o.code = c[0] ? OPC_TRAP : OPC_NONE;
      o.ovf = ~c[0];
      irq_req_i <= c[1];
      dp_i <= {rnd(), 16'(rnd()), 5'(c * 5), c[0], 7'h5a};
      o.operand = 16'(c);
      run(o);
      check_all();
      rd_words();
      wb(1'b1, ADR_IRQ_STS, 4'hf, 32'h7);
      wb(1'b1, ADR_IRQ_MSK, 4'hf, {30'h0, c[1], 1'b1});
    end
    // Random bursts of back-to-back operations
    for (int b = 0; b < 400; b++) begin
      r = rnd();
      dp_i <= {rnd(), r[15:0], 5'(rnd() % 17), r[16], r[31:25]};
      {irq_req_i, nmi_req_i} <= r[18:17];
      for (int k = 0; k <= int'(r[20:19] % 3); k++) begin
        r = rnd();
        o.valid = 1'b1;
        o.code = csfl_opc_t'(5'(1 + r % 19));
        o.cbit = csfl_cbit_t'(3'(rnd() % 7));
        o.flag = r[5];
        o.ovf = (r[8:6] == 3'h0);
        o.operand = 16'(rnd());
        o.ar_val = {14'h0, r[10:9]};
        o.ar0_val = {14'h0, r[12:11]};
        run(o);
      end
      check_all();
      if (b % 50 == 0) rd_words();
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
